// [core/stc_timer.sv]
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_timer
  import stc_pkg::*;
#(
  parameter int NC_LEN = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // cpu byte bus
  input wire stc_io_req_t io_req,
  output logic [7:0] io_rdata,
  // pins and comparator
  input wire logic external_count_pin,
  input wire logic capture_pin,
  input wire logic analog_cmp_out,
  input wire logic analog_capture_sel,
  output logic compare_out_pin_a,
  output logic compare_out_pin_b,
  // timer status and requests
  output logic wide_timer_tick,
  output logic count_at_bottom,
  output logic count_at_max,
  output logic [3:0] irq_req,
  // shared prescaler taps for the 8-bit timer
  output logic [3:0] prescale_taps
);

  logic [1:0] rst_ff;
  wire rst_n = rst_ff[1];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end

  // pin synchronisers: a level counts once stages two and three agree
  logic [2:0] s1, s2, s3, lvl, lvl_d, next_lvl;
  always_comb begin
    next_lvl = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
      lvl <= 3'h0;
      lvl_d <= 3'h0;
    end else begin
      s1 <= {analog_cmp_out, capture_pin, external_count_pin};
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      lvl_d <= lvl;
    end
  end

  wire wr = io_req.wr;
  wire rd = io_req.rd;
  wire [5:0] addr = io_req.addr;
  wire [7:0] wd = io_req.wdata;

  // free running prescaler; taps are registered pulses
  logic [`STC_PRE_W-1:0] pre, next_pre;
  logic [3:0] taps, next_taps;
  logic psr_hit;
  always_comb begin
    psr_hit = wr && addr == `STC_A_SFIO && wd[`STC_PSR_BIT];
    next_pre = pre + 1'b1;
    next_taps = {&pre[`STC_TAP1024_W-1:0], &pre[`STC_TAP256_W-1:0],
                 &pre[`STC_TAP64_W-1:0], &pre[`STC_TAP8_W-1:0]};
    if (psr_hit) begin
      next_pre = '0;
      next_taps = 4'h0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre <= '0;
      taps <= 4'h0;
    end else begin
      pre <= next_pre;
      taps <= next_taps;
    end
  end
  assign prescale_taps = taps;

  // main timer state
  logic [7:0] ctrl_a, ctrl_b, temp, mask, next_ctrl_a, next_ctrl_b, next_temp, next_mask;
  logic [6:0] sfio_hi, next_sfio_hi;
  logic [15:0] cnt, cap, next_cnt, next_cap;
  logic [15:0] cmp_buf [2];
  logic [15:0] cmp_act [2];
  logic [15:0] next_cmp_buf [2];
  logic [15:0] next_cmp_act [2];
  stc_dir_t dir, next_dir;
  stc_irq_t flags, next_flags;
  logic [1:0] outs, next_outs;
  logic [7:0] rdata, next_rdata;
  logic bottom, maxed, next_bottom, next_maxed;
  logic [NC_LEN-1:0] ncan, next_ncan;
  logic cap_lvl, cap_lvl_d, next_cap_lvl;

  logic [3:0] mode;
  logic dual, fast, pwm, icr_top, a_top, tick, at_top, at_bot, ovf, upd, cap_ev, src;
  logic [15:0] top;
  logic [1:0] hit, force_c, com;
  logic [3:0] clr;

  assign mode = {ctrl_b[`STC_WGM32_LSB +: 2], ctrl_a[`STC_WGM10_LSB +: 2]};
  assign dual = mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  assign fast = mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  assign pwm = dual | fast;
  assign icr_top = mode inside {4'h8, 4'hA, 4'hC, 4'hE};
  assign a_top = mode inside {4'h4, 4'h9, 4'hB, 4'hF};

  always_comb begin
    unique case (ctrl_b[`STC_CS_LSB +: 3])
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = taps[0];
      3'h3: tick = taps[1];
      3'h4: tick = taps[2];
      3'h5: tick = taps[3];
      3'h6: tick = lvl_d[`STC_SY_EXT] & ~lvl[`STC_SY_EXT];
      3'h7: tick = lvl[`STC_SY_EXT] & ~lvl_d[`STC_SY_EXT];
    endcase
    top = icr_top ? cap : a_top ? cmp_act[0] : `STC_MAX;
    if (!icr_top && !a_top && !mode[3] && mode[1:0] != 2'h0) begin
      top = (mode[1:0] == 2'h1) ? `STC_TOP8 : (mode[1:0] == 2'h2) ? `STC_TOP9 : `STC_TOP10;
    end
  end
  assign wide_timer_tick = tick;

  always_comb begin
    at_top = cnt == top;
    at_bot = cnt == `STC_BOTTOM;
    // dual slope updates at top too, keeping glitch-free periods
    upd = pwm ? (tick && at_top) : 1'b1;
    hit[0] = tick && cnt == cmp_act[0];
    hit[1] = tick && cnt == cmp_act[1];
    ovf = tick && (dual ? (at_bot && dir == STC_DOWN) : fast ? at_top : cnt == `STC_MAX);
    force_c = 2'h0;
    if (wr && addr == `STC_A_CTRL_A && !pwm) begin
      force_c = {wd[`STC_FOCB_BIT], wd[`STC_FOCA_BIT]};
    end
    // capture source and optional noise canceler
    src = analog_capture_sel ? lvl[`STC_SY_ACO] : lvl[`STC_SY_CAP];
    next_ncan = {ncan[NC_LEN-2:0], src};
    next_cap_lvl = src;
    if (ctrl_b[`STC_ICNC_BIT]) begin
      next_cap_lvl = (&ncan) ? 1'b1 : (~|ncan) ? 1'b0 : cap_lvl;
    end
    // icr as top makes the capture register a setting, not a timestamp
    cap_ev = cap_lvl != cap_lvl_d && cap_lvl == ctrl_b[`STC_ICES_BIT] && !icr_top;
  end

  always_comb begin
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_temp = temp;
    next_mask = mask;
    next_sfio_hi = sfio_hi;
    next_cnt = cnt;
    next_dir = dir;
    next_cap = cap;
    next_cmp_buf = cmp_buf;
    next_cmp_act = cmp_act;
    next_rdata = 8'h00;
    clr = 4'h0;
    if (tick) begin
      if (!dual) begin
        next_cnt = at_top ? `STC_BOTTOM : cnt + 16'h0001;
        next_dir = STC_UP;
      end else if (dir == STC_UP) begin
        next_dir = at_top ? STC_DOWN : STC_UP;
        next_cnt = at_top ? cnt - 16'h0001 : cnt + 16'h0001;
      end else begin
        next_dir = at_bot ? STC_UP : STC_DOWN;
        next_cnt = at_bot ? cnt + 16'h0001 : cnt - 16'h0001;
      end
    end
    if (cap_ev) begin
      next_cap = cnt;
    end
    if (upd) begin
      next_cmp_act = cmp_buf;
    end
    if (wr) begin
      unique case (addr)
        `STC_A_CTRL_A: next_ctrl_a = wd & ~`STC_FOC_MSK;
        `STC_A_CTRL_B: next_ctrl_b = wd;
        `STC_A_CNT_L: next_cnt = {temp, wd};
        `STC_A_CMPA_L: next_cmp_buf[0] = {temp, wd};
        `STC_A_CMPB_L: next_cmp_buf[1] = {temp, wd};
        `STC_A_CAP_L: next_cap = {temp, wd};
        `STC_A_CNT_H, `STC_A_CMPA_H, `STC_A_CMPB_H, `STC_A_CAP_H: next_temp = wd;
        `STC_A_FLAG: clr = wd[`STC_FLAG_LSB +: 4];
        `STC_A_MASK: next_mask = wd;
        `STC_A_SFIO: next_sfio_hi = wd[7:1];
        default: next_temp = temp;
      endcase
    end
    if (rd) begin
      unique case (addr)
        `STC_A_CTRL_A: next_rdata = ctrl_a;
        `STC_A_CTRL_B: next_rdata = ctrl_b;
        `STC_A_CNT_L: begin
          next_rdata = cnt[7:0];
          next_temp = cnt[15:8];
        end
        `STC_A_CNT_H: next_rdata = temp;
        `STC_A_CMPA_L: next_rdata = cmp_buf[0][7:0];
        `STC_A_CMPA_H: next_rdata = cmp_buf[0][15:8];
        `STC_A_CMPB_L: next_rdata = cmp_buf[1][7:0];
        `STC_A_CMPB_H: next_rdata = cmp_buf[1][15:8];
        `STC_A_CAP_L: begin
          next_rdata = cap[7:0];
          next_temp = cap[15:8];
        end
        `STC_A_CAP_H: next_rdata = temp;
        `STC_A_FLAG: next_rdata = {2'h0, flags, 2'h0};
        `STC_A_MASK: next_rdata = mask;
        `STC_A_SFIO: next_rdata = {sfio_hi, 1'b0};
        default: next_rdata = 8'h00;
      endcase
    end
    // a clear in the same cycle as the event loses
    next_flags = stc_irq_t'((flags & ~clr) | {cap_ev, hit[0], hit[1], ovf});
    next_bottom = next_cnt == `STC_BOTTOM;
    next_maxed = next_cnt == `STC_MAX;
  end

  // waveform outputs; fast pwm with com 2 sets at top, then a match clears; com 3 does the reverse; pwm with compare a as top holds output a low
  always_comb begin
    next_outs = outs;
    for (int i = 0; i < 2; i++) begin
      com = (i == 0) ? ctrl_a[`STC_COMA_LSB +: 2] : ctrl_a[`STC_COMB_LSB +: 2];
      if (i == 0 && a_top && pwm) begin
        next_outs[i] = 1'b0;
      end else if (!pwm) begin
        if (hit[i] || force_c[i]) begin
          unique case (com)
            2'h0: next_outs[i] = outs[i];
            2'h1: next_outs[i] = ~outs[i];
            2'h2: next_outs[i] = 1'b0;
            2'h3: next_outs[i] = 1'b1;
          endcase
        end
      end else if (com[1]) begin
        if (fast && tick && at_top) begin
          next_outs[i] = ~com[0];
        end
        if (hit[i]) begin
          next_outs[i] = (fast || dir == STC_UP) ? com[0] : ~com[0];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a <= `STC_RST8;
      ctrl_b <= `STC_RST8;
      temp <= `STC_RST8;
      mask <= `STC_RST8;
      sfio_hi <= 7'h00;
      cnt <= `STC_RST16;
      cap <= `STC_RST16;
      cmp_buf <= '{`STC_RST16, `STC_RST16};
      cmp_act <= '{`STC_RST16, `STC_RST16};
      dir <= STC_UP;
      flags <= '0;
      outs <= 2'h0;
      rdata <= `STC_RST8;
      bottom <= 1'b1;
      maxed <= 1'b0;
      ncan <= '0;
      cap_lvl <= 1'b0;
      cap_lvl_d <= 1'b0;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      temp <= next_temp;
      mask <= next_mask;
      sfio_hi <= next_sfio_hi;
      cnt <= next_cnt;
      cap <= next_cap;
      cmp_buf <= next_cmp_buf;
      cmp_act <= next_cmp_act;
      dir <= next_dir;
      flags <= next_flags;
      outs <= next_outs;
      rdata <= next_rdata;
      bottom <= next_bottom;
      maxed <= next_maxed;
      ncan <= next_ncan;
      cap_lvl <= next_cap_lvl;
      cap_lvl_d <= cap_lvl;
    end
  end

  assign io_rdata = rdata;
  assign compare_out_pin_a = outs[0];
  assign compare_out_pin_b = outs[1];
  assign count_at_bottom = bottom;
  assign count_at_max = maxed;
  assign irq_req = flags & mask[`STC_FLAG_LSB +: 4];

endmodule

// [core/stc_map.svh]
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
// byte addresses on the cpu i/o bus
`define STC_A_CTRL_A 6'h00
`define STC_A_CTRL_B 6'h01
`define STC_A_CNT_L 6'h02
`define STC_A_CNT_H 6'h03
`define STC_A_CMPA_L 6'h04
`define STC_A_CMPA_H 6'h05
`define STC_A_CMPB_L 6'h06
`define STC_A_CMPB_H 6'h07
`define STC_A_CAP_L 6'h08
`define STC_A_CAP_H 6'h09
`define STC_A_FLAG 6'h0A
`define STC_A_MASK 6'h0B
`define STC_A_SFIO 6'h0C
// field positions
`define STC_WGM10_LSB 0
`define STC_WGM32_LSB 3
`define STC_CS_LSB 0
`define STC_ICES_BIT 6
`define STC_ICNC_BIT 7
`define STC_COMA_LSB 6
`define STC_COMB_LSB 4
`define STC_FOCA_BIT 3
`define STC_FOCB_BIT 2
`define STC_FOC_MSK 8'h0C
`define STC_PSR_BIT 0
`define STC_FLAG_LSB 2
// reset values
`define STC_RST8 8'h00
`define STC_RST16 16'h0000
// count limits
`define STC_BOTTOM 16'h0000
`define STC_MAX 16'hFFFF
`define STC_TOP8 16'h00FF
`define STC_TOP9 16'h01FF
`define STC_TOP10 16'h03FF
// prescaler taps: low bits all ones gives /8 /64 /256 /1024
`define STC_PRE_W 10
`define STC_TAP8_W 3
`define STC_TAP64_W 6
`define STC_TAP256_W 8
`define STC_TAP1024_W 10
// synchroniser lanes
`define STC_SY_EXT 0
`define STC_SY_CAP 1
`define STC_SY_ACO 2
`endif

// [core/stc_pkg.sv]
package stc_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } stc_io_req_t;
  // bit order matches flag and mask bits 5..2
  typedef struct packed {
    logic capture;
    logic match_a;
    logic match_b;
    logic overflow;
  } stc_irq_t;
  typedef enum logic {STC_UP = 1'b0, STC_DOWN = 1'b1} stc_dir_t;
endpackage

// [tb/stc_timer_monitor.sv]
`timescale 1ns/1ps
`include "stc_map.svh"
module stc_timer_monitor
  import stc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // cpu bus
  input wire stc_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  // timer status
  input wire logic wide_timer_tick,
  input wire logic count_at_bottom,
  input wire logic count_at_max,
  input wire logic [3:0] irq_req,
  input wire logic [3:0] prescale_taps
);
  logic [2:0] cs_seen;
  logic [2:0] next_cs;
  logic [3:0] mask_seen;
  logic [3:0] next_mask;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // shadows of select and mask, so tick and irq can be tied to their cause
  always_comb begin
    next_cs = cs_seen;
    next_mask = mask_seen;
    if (io_req.wr && io_req.addr == `STC_A_CTRL_B) begin
      next_cs = io_req.wdata[2:0];
    end
    if (io_req.wr && io_req.addr == `STC_A_MASK) begin
      next_mask = io_req.wdata[5:2];
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cs_seen <= 3'h0;
      mask_seen <= 4'h0;
    end else begin
      cs_seen <= next_cs;
      mask_seen <= next_mask;
    end
  end
  rdata_idle_a: assert property (!io_req.rd |=> io_rdata == 8'h00)
    else $error("read data not zero without a read");
  psr_reads_zero_a: assert property (
    io_req.rd && io_req.addr == `STC_A_SFIO |=> !io_rdata[0])
    else $error("prescaler reset bit read back as one");
  psr_restart_a: assert property (
    io_req.wr && io_req.addr == `STC_A_SFIO && io_req.wdata[0] |=> !prescale_taps[0] [*7])
    else $error("tap pulse too soon after prescaler reset");
  stopped_tick_a: assert property (cs_seen == 3'h0 |-> !wide_timer_tick)
    else $error("tick with no clock source");
  direct_tick_a: assert property (cs_seen == 3'h1 |-> wide_timer_tick)
    else $error("no tick with undivided clock");
  irq_masked_a: assert property ((irq_req & ~mask_seen) == 4'h0)
    else $error("request on a masked source");
  bottom_max_a: assert property (!(count_at_bottom && count_at_max))
    else $error("bottom and max both flagged");
  tap_period_a: assert property (prescale_taps[0] |=> !prescale_taps[0] [*7])
    else $error("divide by 8 tap too frequent");
  tap_nested_a: assert property (
    prescale_taps[1] |-> prescale_taps[0] && !$past(prescale_taps[1]))
    else $error("divide by 64 tap out of phase");
  cover property (irq_req != 4'h0);
endmodule
bind stc_timer stc_timer_monitor mon (.clock(clock), .resetn(resetn), .io_req(io_req),
  .io_rdata(io_rdata), .wide_timer_tick(wide_timer_tick), .count_at_bottom(count_at_bottom),
  .count_at_max(count_at_max), .irq_req(irq_req), .prescale_taps(prescale_taps));

// [tb/stc_cpu_model.sv]
`timescale 1ns/1ps
module stc_cpu_model
  import stc_pkg::*;
(
  // clock
  input wire logic clock,
  // cpu bus
  output stc_io_req_t io_req,
  input wire logic [7:0] io_rdata
);
  initial io_req = '0;
  // released bus shows inverted leftovers, never a tidy zero
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock);
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h5A};
    @(posedge clock);
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};
    #1;
    d = io_rdata;
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a + 6'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 6'h01, d[15:8]);
  endtask
endmodule

// [tb/sixteen_bit_timer_core_bench.sv]
`timescale 1ns/1ps
`include "stc_map.svh"
module sixteen_bit_timer_core_bench;
  logic clock;
  logic resetn;
  stc_pkg::stc_io_req_t io_req;
  logic [7:0] io_rdata;
  logic external_count_pin;
  logic capture_pin;
  logic analog_cmp_out;
  logic analog_capture_sel;
  logic [3:0] irq_req;
  logic [3:0] prescale_taps;
  logic count_at_max;
  logic max_seen = 1'b0;
  logic pin_a;
  logic pin_b;
  logic [7:0] b;
  logic [15:0] got;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  stc_timer dut (.clock(clock), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
    .external_count_pin(external_count_pin), .capture_pin(capture_pin),
    .analog_cmp_out(analog_cmp_out), .analog_capture_sel(analog_capture_sel),
    .compare_out_pin_a(pin_a), .compare_out_pin_b(pin_b),
    .wide_timer_tick(), .count_at_bottom(),
    .count_at_max(count_at_max), .irq_req(irq_req), .prescale_taps(prescale_taps));
  stc_cpu_model cpu (.clock(clock), .io_req(io_req), .io_rdata(io_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // generous ceiling: the sequence needs well under two thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    max_seen <= max_seen | count_at_max;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    resetn = 1'b0;
    external_count_pin = 1'b0;
    capture_pin = 1'b0;
    analog_cmp_out = 1'b0;
    analog_capture_sel = 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    for (int a = 0; a <= 12; a++) begin
      cpu.rd8(6'(a), b);
      check({8'h00, b}, 16'h0000);
    end
    cpu.rd8(6'h20, b);
    check({8'h00, b}, 16'h0000);
    // force acts with the output action already stored: toggle a, set b
    cpu.wr8(`STC_A_CTRL_A, 8'h70);
    cpu.wr8(`STC_A_CTRL_A, 8'h7C);
    @(negedge clock);
    check({14'h0000, pin_b, pin_a}, 16'h0003);
    cpu.wr8(`STC_A_CTRL_A, 8'h3F);
    cpu.rd8(`STC_A_CTRL_A, b);
    check({8'h00, b}, 16'h0033);
    cpu.wr8(`STC_A_CTRL_B, 8'h18);
    cpu.rd8(`STC_A_CTRL_B, b);
    check({8'h00, b}, 16'h0018);
    cpu.wr8(`STC_A_CTRL_A, 8'h00);
    cpu.wr8(`STC_A_CTRL_B, 8'h00);
    cpu.wr16(`STC_A_CNT_L, 16'h1234);
    repeat (5) @(posedge clock);
    cpu.rd16(`STC_A_CNT_L, got);
    check(got, 16'h1234);
    cpu.wr16(`STC_A_CMPA_L, 16'hAB77);
    cpu.rd8(`STC_A_CNT_L, b);
    cpu.rd16(`STC_A_CMPA_L, got);
    check(got, 16'hAB77);
    cpu.rd8(`STC_A_CNT_H, b);
    check({8'h00, b}, 16'h0012);
    // one staged high byte serves both compare writes
    cpu.wr8(`STC_A_CNT_H, 8'h00);
    cpu.wr8(`STC_A_CMPB_L, 8'h0C);
    cpu.wr8(`STC_A_CMPA_L, 8'h10);
    cpu.rd16(`STC_A_CMPB_L, got);
    check(got, 16'h000C);
    cpu.wr16(`STC_A_CNT_L, 16'h0008);
    cpu.wr8(`STC_A_MASK, 8'h3C);
    cpu.wr8(`STC_A_CTRL_B, 8'h01);
    repeat (20) @(posedge clock);
    cpu.wr8(`STC_A_CTRL_B, 8'h00);
    cpu.rd8(`STC_A_FLAG, b);
    check({8'h00, b}, 16'h0018);
    check({12'h000, irq_req}, 16'h0006);
    cpu.wr8(`STC_A_FLAG, 8'hFF);
    cpu.wr16(`STC_A_CNT_L, 16'hFFF8);
    cpu.wr8(`STC_A_CTRL_B, 8'h01);
    repeat (12) @(posedge clock);
    cpu.wr8(`STC_A_CTRL_B, 8'h00);
    cpu.rd8(`STC_A_FLAG, b);
    check({8'h00, b}, 16'h0004);
    check({15'h0000, max_seen}, 16'h0001);
    cpu.wr8(`STC_A_FLAG, 8'hFF);
    cpu.rd8(`STC_A_FLAG, b);
    check({8'h00, b}, 16'h0000);
    cpu.wr8(`STC_A_CTRL_B, 8'hC0);
    cpu.wr16(`STC_A_CNT_L, 16'h0555);
    capture_pin <= 1'b1;
    repeat (10) @(posedge clock);
    cpu.rd8(`STC_A_FLAG, b);
    check({8'h00, b}, 16'h0020);
    cpu.rd16(`STC_A_CAP_L, got);
    check(got, 16'h0555);
    cpu.wr8(`STC_A_CTRL_B, 8'h47);
    repeat (6) begin
      repeat (4) @(posedge clock);
      external_count_pin <= ~external_count_pin;
    end
    repeat (8) @(posedge clock);
    cpu.rd16(`STC_A_CNT_L, got);
    check(got, 16'h0558);
    // comparator as capture source; switching to its low level is a falling edge
    cpu.wr8(`STC_A_FLAG, 8'hFF);
    analog_capture_sel <= 1'b1;
    repeat (4) @(posedge clock);
    analog_cmp_out <= 1'b1;
    repeat (10) @(posedge clock);
    cpu.rd16(`STC_A_CAP_L, got);
    check(got, 16'h0558);
    cpu.rd8(`STC_A_FLAG, b);
    check({8'h00, b}, 16'h0020);
    cpu.wr8(`STC_A_SFIO, 8'hFF);
    cpu.rd8(`STC_A_SFIO, b);
    check({8'h00, b}, 16'h00FE);
    repeat (80) @(posedge clock);
    give_verdict();
  end
endmodule
